// ---- ralm_map.vh ----
// Purpose : Constants for the resolver angle and loss monitor
// Assumes : Included by ralm_top.v and ralm_cordic.v by bare name
// Notes   : Register offsets are byte addresses on the local port
`ifndef RALM_MAP_VH
`define RALM_MAP_VH

// Clock and phase cycle timing
`define RALM_CLK_PERIOD_NS     8
`define RALM_PHASE_PERIOD_NS   10000
`define RALM_PHASE_CYCLES      (`RALM_PHASE_PERIOD_NS / `RALM_CLK_PERIOD_NS)

// Register byte offsets
`define RALM_OFS_ANGLE_MAG     8'h00
`define RALM_OFS_STATUS        8'h04
`define RALM_OFS_RESULT0       8'h08
`define RALM_OFS_RESULT1       8'h0c
`define RALM_OFS_RESULT2       8'h10
`define RALM_OFS_RESULT3       8'h14
`define RALM_OFS_OFFSET0       8'h18
`define RALM_OFS_OFFSET1       8'h1c

// Field positions
`define RALM_ANGLE_MSB         31
`define RALM_ANGLE_LSB         16
`define RALM_MAG_MSB           15
`define RALM_MAG_LSB           0
`define RALM_LOSS_BIT          31
`define RALM_BUSY_BIT          0
`define RALM_LOSS_NIB_MSB      15
`define RALM_LOSS_NIB_LSB      12

// Reset values
`define RALM_RST_WORD          32'h0000_0000
`define RALM_RST_SAMPLE        16'h0000
`define RALM_RST_OFFSET        16'h0000
`define RALM_RST_LOSS          1'b1

// Arctangent engine
`define RALM_CORDIC_STEPS      16
`define RALM_HALF_TURN         16'h8000

`endif

// ---- ralm_cordic.v ----
// Purpose : Iterative vectoring arctangent, one step per clock
// Assumes : Start only while not busy; inputs held for the start cycle
// Notes   : 65536 angle states per turn, wraps naturally at 16 bits
`timescale 1ns/10ps
`default_nettype none
`include "ralm_map.vh"

module ralm_cordic (
  input  wire               core_clk,
  input  wire               srst,
  input  wire               start,
  input  wire signed [16:0] x_in,
  input  wire signed [16:0] y_in,
  output wire               busy,
  output reg                done,
  output reg         [15:0] angle
);

  reg signed [19:0] x_q;
  reg signed [19:0] y_q;
  reg        [15:0] z_q;
  reg        [3:0]  step_q;
  reg               busy_q;
  wire signed [19:0] x_ext;
  wire signed [19:0] y_ext;
  wire signed [19:0] x_sh;
  wire signed [19:0] y_sh;
  wire       [15:0] tbl;

  // Angle of each micro-rotation, turn scaled to 65536
  function [15:0] atan_step;
    input [3:0] i;
    begin
      case (i)
        4'h0:    atan_step = 16'h2000;
        4'h1:    atan_step = 16'h12e4;
        4'h2:    atan_step = 16'h09fb;
        4'h3:    atan_step = 16'h0511;
        4'h4:    atan_step = 16'h028b;
        4'h5:    atan_step = 16'h0146;
        4'h6:    atan_step = 16'h00a3;
        4'h7:    atan_step = 16'h0051;
        4'h8:    atan_step = 16'h0029;
        4'h9:    atan_step = 16'h0014;
        4'ha:    atan_step = 16'h000a;
        4'hb:    atan_step = 16'h0005;
        4'hc:    atan_step = 16'h0003;
        4'hd:    atan_step = 16'h0001;
        4'he:    atan_step = 16'h0001;
        default: atan_step = 16'h0000;
      endcase
    end
  endfunction

  assign x_ext = {{3{x_in[16]}}, x_in};
  assign y_ext = {{3{y_in[16]}}, y_in};
  assign x_sh  = x_q >>> step_q;
  assign y_sh  = y_q >>> step_q;
  assign tbl   = atan_step(step_q);
  assign busy  = busy_q;

  // Left half-plane folded by a half turn, then micro-rotations
  always @(posedge core_clk) begin
    if (srst) begin
      x_q    <= 20'h00000;
      y_q    <= 20'h00000;
      z_q    <= 16'h0000;
      step_q <= 4'h0;
      busy_q <= 1'b0;
      done   <= 1'b0;
      angle  <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        step_q <= 4'h0;
        if (x_in[16]) begin
          x_q <= -x_ext;
          y_q <= -y_ext;
          z_q <= `RALM_HALF_TURN;
        end else begin
          x_q <= x_ext;
          y_q <= y_ext;
          z_q <= 16'h0000;
        end
      end else if (busy_q) begin
        if (y_q[19]) begin
          x_q <= x_q - y_sh;
          y_q <= y_q + x_sh;
          z_q <= z_q - tbl;
        end else begin
          x_q <= x_q + y_sh;
          y_q <= y_q - x_sh;
          z_q <= z_q + tbl;
        end
        step_q <= step_q + 4'h1;
        if (step_q == 4'hf) begin
          busy_q <= 1'b0;
          done   <= 1'b1;
          angle  <= y_q[19] ? (z_q - tbl) : (z_q + tbl);
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- ralm_top.v ----
// Purpose : Resolver readout: angle, magnitude and sensor-loss status
// Assumes : Converter words arrive from another domain and are resynced
// Notes   : All results refresh once per internal phase cycle
//
// Behaviour
// R1 - The arctangent angle sits in bits 31 to 16 of the combined word.
// R2 - One electrical cycle spans the full 16-bit angle range and wraps.
// R3 - Magnitude is the sum of the squared sine and cosine samples.
// R4 - Magnitude is a 16-bit unsigned field in the low half of the word.
// R5 - Loss flag is set when the top four magnitude bits are all zero.
// R6 - The loss flag is bit 31 of the channel status word.
// R7 - The loss flag is high for signal loss and low when healthy.
// R8 - Aux sine and cosine raw samples read back in results two and three.
// R9 - No edge capture; a new angle appears only once per phase cycle.
// R10 - Magnitude is recomputed every phase cycle from primary readings.
// R11 - Programmable offsets are added to sine and cosine before atan.
// R12 - Loss flag is re-evaluated every phase cycle and clears on recovery.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ralm_map.vh"

module ralm_top (
  input  wire        core_clk,
  input  wire        srst,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire [15:0] adc_sine,
  input  wire [15:0] adc_cosine,
  input  wire [15:0] aux_sine_input,
  input  wire [15:0] aux_cosine_input,
  output wire        phase_tick,
  output wire        sensor_loss_flag
);

  // Phase divider terminal count
  localparam [31:0] DIV_FULL = `RALM_PHASE_CYCLES - 1;
  localparam [10:0] DIV_LAST = DIV_FULL[10:0];

  // One-hot conversion sequencer states
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_START = 3'b010;
  localparam [2:0] ST_WAIT  = 3'b100;

  // Synchroniser stages for the converter words
  reg  [15:0] sin_m_q;
  reg  [15:0] sin_s_q;
  reg  [15:0] cos_m_q;
  reg  [15:0] cos_s_q;
  reg  [15:0] asin_m_q;
  reg  [15:0] asin_s_q;
  reg  [15:0] acos_m_q;
  reg  [15:0] acos_s_q;

  // Phase divider
  reg  [10:0] div_q;
  reg         tick_q;

  // Sampled converter results
  reg  [15:0] result0_q;
  reg  [15:0] result1_q;
  reg  [15:0] result2_q;
  reg  [15:0] result3_q;

  // Software offsets
  reg  [15:0] offset0_q;
  reg  [15:0] offset1_q;

  // Magnitude pipeline
  reg  [31:0] sq_sin_q;
  reg  [31:0] sq_cos_q;
  wire [31:0] sq_sum;
  wire [15:0] mag_field;

  // Sequencer and results
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [31:0] word_q;
  reg         loss_q;

  // Arctangent engine connections
  wire signed [16:0] cx;
  wire signed [16:0] cy;
  wire               eng_start;
  wire               eng_busy;
  wire               eng_done;
  wire        [15:0] eng_angle;

  // Register decode
  wire        sel_off0;
  wire        sel_off1;
  reg  [31:0] rd_mux;

  // Two-stage resync of the external converter words
  always @(posedge core_clk) begin
    if (srst) begin
      sin_m_q  <= `RALM_RST_SAMPLE;
      sin_s_q  <= `RALM_RST_SAMPLE;
      cos_m_q  <= `RALM_RST_SAMPLE;
      cos_s_q  <= `RALM_RST_SAMPLE;
      asin_m_q <= `RALM_RST_SAMPLE;
      asin_s_q <= `RALM_RST_SAMPLE;
      acos_m_q <= `RALM_RST_SAMPLE;
      acos_s_q <= `RALM_RST_SAMPLE;
    end else begin
      sin_m_q  <= adc_sine;
      sin_s_q  <= sin_m_q;
      cos_m_q  <= adc_cosine;
      cos_s_q  <= cos_m_q;
      asin_m_q <= aux_sine_input;
      asin_s_q <= asin_m_q;
      acos_m_q <= aux_cosine_input;
      acos_s_q <= acos_m_q;
    end
  end

  // Phase cycle enable, one pulse per period
  always @(posedge core_clk) begin
    if (srst) begin
      div_q  <= 11'h000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == DIV_LAST);
      if (div_q == DIV_LAST) begin
        div_q <= 11'h000;
      end else begin
        div_q <= div_q + 11'h001;
      end
    end
  end

  assign phase_tick = tick_q;

  // Converter results latched only on the phase pulse
  always @(posedge core_clk) begin
    if (srst) begin
      result0_q <= `RALM_RST_SAMPLE;
      result1_q <= `RALM_RST_SAMPLE;
      result2_q <= `RALM_RST_SAMPLE;
      result3_q <= `RALM_RST_SAMPLE;
    end else if (tick_q) begin                      // see R9
      result0_q <= sin_s_q;
      result1_q <= cos_s_q;
      result2_q <= asin_s_q;                        // see R8
      result3_q <= acos_s_q;                        // see R8
    end
  end

  // Offset writes from software
  assign sel_off0 = (reg_addr == `RALM_OFS_OFFSET0);
  assign sel_off1 = (reg_addr == `RALM_OFS_OFFSET1);

  always @(posedge core_clk) begin
    if (srst) begin
      offset0_q <= `RALM_RST_OFFSET;
      offset1_q <= `RALM_RST_OFFSET;
    end else if (reg_wr) begin
      if (sel_off0) begin
        offset0_q <= reg_wdata[15:0];
      end
      if (sel_off1) begin
        offset1_q <= reg_wdata[15:0];
      end
    end
  end

  // Compensated inputs to the arctangent, one bit of headroom
  assign cy = $signed({result0_q[15], result0_q})
            + $signed({offset0_q[15], offset0_q});   // see R11
  assign cx = $signed({result1_q[15], result1_q})
            + $signed({offset1_q[15], offset1_q});   // see R11

  // Squares of the raw primary samples
  always @(posedge core_clk) begin
    if (srst) begin
      sq_sin_q <= 32'h0000_0000;
      sq_cos_q <= 32'h0000_0000;
    end else if (state_q == ST_START) begin          // see R10
      sq_sin_q <= $signed(result0_q) * $signed(result0_q); // see R3
      sq_cos_q <= $signed(result1_q) * $signed(result1_q); // see R3
    end
  end

  // Sum scaled so one full-scale channel reads 32768, saturating
  assign sq_sum    = sq_sin_q + sq_cos_q;             // see R3
  assign mag_field = sq_sum[31] ? 16'hffff : sq_sum[30:15];

  // Sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (tick_q) begin
          state_d = ST_START;
        end
      end
      ST_START: begin
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (eng_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign eng_start = (state_q == ST_START);

  // Arctangent engine, cosine on the x axis
  ralm_cordic u_cordic (
    .core_clk (core_clk),
    .srst     (srst),
    .start    (eng_start),
    .x_in     (cx),
    .y_in     (cy),
    .busy     (eng_busy),
    .done     (eng_done),
    .angle    (eng_angle)
  );

  // Combined word and loss flag updated together once per phase cycle
  always @(posedge core_clk) begin
    if (srst) begin
      word_q <= `RALM_RST_WORD;
      loss_q <= `RALM_RST_LOSS;
    end else if (eng_done && state_q == ST_WAIT) begin   // see R9
      word_q[`RALM_ANGLE_MSB:`RALM_ANGLE_LSB] <= eng_angle; // see R1, R2
      word_q[`RALM_MAG_MSB:`RALM_MAG_LSB]     <= mag_field; // see R4, R10
      loss_q <= (mag_field[`RALM_LOSS_NIB_MSB:`RALM_LOSS_NIB_LSB]
                 == 4'h0);                            // see R5, R7, R12
    end
  end

  assign sensor_loss_flag = loss_q;                   // see R7

  // Read multiplexer, unmapped addresses read zero
  always @* begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      `RALM_OFS_ANGLE_MAG: begin
        rd_mux = word_q;
      end
      `RALM_OFS_STATUS: begin
        rd_mux[`RALM_LOSS_BIT] = loss_q;              // see R6
        rd_mux[`RALM_BUSY_BIT] = eng_busy;
      end
      `RALM_OFS_RESULT0: begin
        rd_mux[15:0] = result0_q;
      end
      `RALM_OFS_RESULT1: begin
        rd_mux[15:0] = result1_q;
      end
      `RALM_OFS_RESULT2: begin
        rd_mux[15:0] = result2_q;                     // see R8
      end
      `RALM_OFS_RESULT3: begin
        rd_mux[15:0] = result3_q;                     // see R8
      end
      `RALM_OFS_OFFSET0: begin
        rd_mux[15:0] = offset0_q;
      end
      `RALM_OFS_OFFSET1: begin
        rd_mux[15:0] = offset1_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// ---- ralm_properties.sv ----
// Purpose : Port checks for the resolver readout block
// Assumes : One clock, synchronous active-high reset
// Notes   : Bound to ralm_top at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module ralm_properties (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] adc_sine,
  input wire logic [15:0] adc_cosine,
  input wire logic [15:0] aux_sine_input,
  input wire logic [15:0] aux_cosine_input,
  input wire logic        phase_tick,
  input wire logic        sensor_loss_flag
);
  logic [10:0] cnt_q;
  logic        seen_q;
  logic        rda_q;
  logic        have_q;
  logic [31:0] word_q;
  logic [15:0] aux1_q;
  logic [15:0] aux2_q;
  logic [15:0] aux_q;
  wire         win = cnt_q > 11'd9 && cnt_q < 11'd26;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Cycles since last tick, last word read, aux word as latched
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q  <= 11'h000;
      seen_q <= 1'b0;
      rda_q  <= 1'b0;
      have_q <= 1'b0;
      word_q <= 32'h0;
      aux_q  <= 16'h0;
    end else begin
      cnt_q  <= phase_tick ? 11'h000 : cnt_q + 11'h001;
      seen_q <= seen_q | phase_tick;
      rda_q  <= reg_rd && reg_addr == 8'h00;
      have_q <= (rda_q | have_q) & ~win;
      word_q <= rda_q ? reg_rdata : word_q;
      aux_q  <= phase_tick ? aux2_q : aux_q;
    end
  end
  // Two-stage view of the aux input, as the resync sees it
  always_ff @(posedge core_clk) begin
    aux1_q <= aux_sine_input;
    aux2_q <= aux1_q;
  end
  a_tick_period: assert property (
    seen_q |-> phase_tick == (cnt_q == 11'd1249)) else $error("tick period");
  a_tick_single: assert property (
    phase_tick |=> !phase_tick [*8]) else $error("tick too long");
  a_loss_status: assert property (
    reg_rd && reg_addr == 8'h04 |=>
    reg_rdata[31:1] == {$past(sensor_loss_flag), 30'h0})
    else $error("status word");
  a_loss_nibble: assert property (
    reg_rd && reg_addr == 8'h00 |=>
    (reg_rdata[15:12] == 4'h0) == $past(sensor_loss_flag))
    else $error("loss vs magnitude");
  a_loss_window: assert property (
    $changed(sensor_loss_flag) |-> cnt_q > 11'd14 && cnt_q < 11'd22)
    else $error("loss flag moved off cycle");
  a_word_hold: assert property (
    rda_q && have_q |-> reg_rdata == word_q) else $error("word moved");
  a_offset_rw: assert property (
    reg_wr && reg_addr == 8'h18 ##1 reg_rd && reg_addr == 8'h18 |=>
    reg_rdata == ($past(reg_wdata, 2) & 32'h0000ffff))
    else $error("offset readback");
  a_aux_raw: assert property (
    reg_rd && reg_addr == 8'h10 |=> reg_rdata == {16'h0, $past(aux_q)})
    else $error("aux raw word");
  c_loss_set: cover property ($rose(sensor_loss_flag));
  c_loss_clear: cover property ($fell(sensor_loss_flag));
  c_offset_rw: cover property (reg_wr ##1 reg_rd);
endmodule
bind ralm_top ralm_properties ralm_properties_i (.core_clk(core_clk),
  .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .adc_sine(adc_sine), .adc_cosine(adc_cosine),
  .aux_sine_input(aux_sine_input), .aux_cosine_input(aux_cosine_input),
  .phase_tick(phase_tick), .sensor_loss_flag(sensor_loss_flag));
`default_nettype wire

// ---- ralm_adc_model.sv ----
// Purpose : Converter side of the resolver readout
// Assumes : Words refresh once per phase cycle
// Notes   : Change lands just after a tick, steady for the next
`timescale 1ns/10ps
`default_nettype none
module ralm_adc_model (
  input  wire logic        core_clk,
  input  wire logic        phase_tick,
  input  wire logic [63:0] cmd,
  output var  logic [15:0] adc_sine,
  output var  logic [15:0] adc_cosine,
  output var  logic [15:0] aux_sine,
  output var  logic [15:0] aux_cosine
);
  // Zero words before the first conversion
  initial begin
    {adc_sine, adc_cosine, aux_sine, aux_cosine} = 64'h0;
  end
  // New conversion right after each tick
  always @(posedge core_clk) begin
    if (phase_tick) begin
      {adc_sine, adc_cosine, aux_sine, aux_cosine} <= cmd;
    end
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Purpose : Self-checking bench for the resolver readout
// Assumes : Converter model holds words across each tick
// Notes   : Angle within 8 LSB, magnitude exact
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        core_clk  = 1'b0;
  logic        srst      = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  logic        phase_tick;
  logic        sensor_loss_flag;
  logic [15:0] a_s, a_c, x_s, x_c;
  logic [15:0] rv [4]  = '{16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] cs [6]  = '{16'h0, 16'h4000, 16'h8000,
                           16'h2000, 16'h2000, 16'h0};
  logic [15:0] cc [6]  = '{16'h7fff, 16'h0, 16'h8000,
                           16'h1fff, 16'h2000, 16'h0};
  logic [15:0] off_s, off_c, e_m;
  logic [31:0] d;
  int          failures = 0;
  int          n_checks = 0;

  // Design under test and converter model
  ralm_top ralm_top_i (.core_clk(core_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_sine(a_s),
    .adc_cosine(a_c), .aux_sine_input(x_s), .aux_cosine_input(x_c),
    .phase_tick(phase_tick), .sensor_loss_flag(sensor_loss_flag));
  ralm_adc_model ralm_adc_model_i (.core_clk(core_clk),
    .phase_tick(phase_tick), .cmd({rv[0], rv[1], rv[2], rv[3]}),
    .adc_sine(a_s), .adc_cosine(a_c), .aux_sine(x_s), .aux_cosine(x_c));

  always #4 core_clk = ~core_clk;

  task automatic finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Compare with a wrapping tolerance
  task automatic chk(input logic [31:0] g, e, tol);
    n_checks++;
    if ((g - e + tol <= 2 * tol) !== 1'b1) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is taken at the edge that ends its one cycle
  task automatic rd(input logic [7:0] a);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask

  task automatic wait_tick;
    int i;
    i = 0;
    while (phase_tick !== 1'b1) begin
      @(posedge core_clk);
      i++;
      if (i > 1300) begin
        failures++;
        finish_test();
      end
    end
    @(posedge core_clk);
  endtask

  // Model takes words at one tick, design at the next
  task automatic settle;
    @(posedge core_clk);
    wait_tick();
    wait_tick();
    repeat (25) @(posedge core_clk);
  endtask

  function automatic logic [15:0] exp_mag(input logic [15:0] s, c);
    logic [31:0] r;
    r = $signed(s) * $signed(s) + $signed(c) * $signed(c);
    exp_mag = r[31] ? 16'hffff : r[30:15];
  endfunction

  function automatic logic [15:0] exp_ang(input logic [15:0] s, c);
    real y;
    real x;
    y = $signed(s);
    y = y + $signed(off_s);
    x = $signed(c);
    x = x + $signed(off_c);
    exp_ang = 16'(int'($floor($atan2(y, x) * 10430.378 + 0.5)));
  endfunction

  initial begin
    void'($urandom(99));
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    // Reset values; writes to read-only and unmapped places ignored
    chk(sensor_loss_flag, 32'h1, 0);
    wr(8'h00, 32'hffff_ffff);
    @(posedge core_clk);
    wr(8'h10, 32'h1234_5678);
    @(posedge core_clk);
    wr(8'h24, 32'h1234_5678);
    for (int k = 0; k < 9; k++) begin
      rd(8'(k * 4));
      chk(d, k == 1 ? 32'h8000_0000 : 32'h0, 0);
    end
    $display("test reset_values done");
    // Corner vectors first, then random ones with offsets
    for (int t = 0; t < 12; t++) begin
      off_s = t < 6 ? 16'h0 : 16'($urandom_range(511)) - 16'h0100;
      off_c = t < 6 ? 16'h0 : 16'($urandom_range(511)) - 16'h0100;
      wr(8'h18, {16'hffff, off_s});
      rd(8'h18);
      chk(d, {16'h0, off_s}, 0);
      wr(8'h1c, {16'hffff, off_c});
      rd(8'h1c);
      chk(d, {16'h0, off_c}, 0);
      rv[0] <= t < 6 ? cs[t] : 16'($urandom);
      rv[1] <= t < 6 ? cc[t] : 16'($urandom);
      rv[2] <= 16'($urandom);
      rv[3] <= 16'($urandom);
      settle();
      e_m = exp_mag(rv[0], rv[1]);
      rd(8'h00);
      chk(d[15:0], e_m, 0);
      if (e_m[15:12] != 4'h0) begin
        chk(d & 32'hffff0000, {exp_ang(rv[0], rv[1]), 16'h0}, 32'h80000);
      end
      rd(8'h00);
      chk(d[15:0], e_m, 0);
      chk(sensor_loss_flag, e_m[15:12] == 4'h0, 0);
      rd(8'h04);
      chk(d, {e_m[15:12] == 4'h0, 31'h0}, 0);
      for (int k = 0; k < 4; k++) begin
        rd(8'(8 + 4 * k));
        chk(d, {16'h0, rv[k]}, 0);
      end
      $display("test case %0d done", t);
    end
    // Reset in mid-run brings loss back and clears the word
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    chk(sensor_loss_flag, 32'h1, 0);
    rd(8'h00);
    chk(d, 32'h0, 0);
    $display("test midrun_reset done");
    finish_test();
  end
endmodule
`default_nettype wire
